// ---- ccs_regs.vh ----
// Register map, field positions, reset values and timing constants of the colour sensor control
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
// ****************************************************************
// Register addresses
// ****************************************************************
`define CCS_ADDR_FUNC_CTRL 5'h00
`define CCS_ADDR_INTEG_TIME 5'h01
`define CCS_ADDR_WAIT_TIME 5'h03
`define CCS_ADDR_LOW_THR_LO 5'h04
`define CCS_ADDR_LOW_THR_HI 5'h05
`define CCS_ADDR_HIGH_THR_LO 5'h06
`define CCS_ADDR_HIGH_THR_HI 5'h07
`define CCS_ADDR_INT_FILTER 5'h0c
`define CCS_ADDR_WAIT_CONFIG 5'h0d
`define CCS_ADDR_STATUS 5'h13
`define CCS_ADDR_CLEAR_LO 5'h14
`define CCS_ADDR_CLEAR_HI 5'h15
// ****************************************************************
// Field positions
// ****************************************************************
`define CCS_BIT_OSC_ON 0
`define CCS_BIT_MEASURE_ON 1
`define CCS_BIT_WAIT_ON 3
`define CCS_BIT_IRQ_ALLOW 4
`define CCS_BIT_WAIT_X12 1
`define CCS_BIT_RESULT_VALID 0
`define CCS_BIT_IRQ_FLAG 4
`define CCS_FUNC_CTRL_MASK 8'h1b
`define CCS_WAIT_CONFIG_MASK 8'h02
`define CCS_FILTER_MASK 8'h0f
// ****************************************************************
// Reset values and command codes
// ****************************************************************
`define CCS_RST_FUNC_CTRL 8'h00
`define CCS_RST_INTEG_TIME 8'hff
`define CCS_RST_WAIT_TIME 8'hff
`define CCS_RST_ZERO 8'h00
`define CCS_SF_IRQ_CLEAR 5'h06
// ****************************************************************
// Timing
// ****************************************************************
`define CCS_CLOCK_HZ 250000000
`define CCS_STEP_US 2400
`define CCS_STEP_CYCLES ((`CCS_CLOCK_HZ / 1000000) * `CCS_STEP_US)
`define CCS_LONG_FACTOR 12
`define CCS_LONG_LAST 4'hb
`define CCS_COUNTS_PER_STEP 19'h00400
`define CCS_MAX_COUNT 17'h0ffff
`endif

// ---- ccs_step_timer.v ----
// Step timer: emits one pulse per step of a programmable number of clock cycles
module ccs_step_timer #(
   parameter STEP_CYCLES = 600000,
   parameter WIDTH = 24
) (
   input wire clock,
   input wire rst,
   input wire clock_en,
   input wire run,
   output reg step_done
);
   reg [WIDTH-1:0] count;
   // ****************************************************************
   // Counter restarts whenever run drops
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= {WIDTH{1'b0}};
         step_done <= 1'b0;
      end else if (clock_en) begin
         step_done <= 1'b0;
         if (!run) begin
            count <= {WIDTH{1'b0}};
         end else if (count == STEP_CYCLES[WIDTH-1:0] - 1'b1) begin
            count <= {WIDTH{1'b0}};
            step_done <= 1'b1;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule

// ---- ccs_ctrl.v ----
// Colour sensor sequencing, threshold filter and register file
// How it works
// - Oscillator bit gates all timers and conversions
// - Measure bit enables colour measurement
// - Wait bit inserts wait period between measurements
// - Interrupt allow bit gates interrupt raising
// - First measurement starts one step after power-on
// - Integration lasts 256 minus setting steps
// - Result full scale steps times 1024, saturating
// - Wait lasts 256 minus setting steps
// - Long-wait bit makes wait steps twelve times longer
// - Clear result outside thresholds counts out-of-range
// - Thresholds built from byte pairs at 0x04-0x07
// - Filter code zero interrupts every cycle
// - Filter code N below 4 needs N consecutive out-of-range results, codes 4 to 15 need 5*(N-3)
// - Clear command code 00110 drops pending interrupt
// - Status bit zero flags completed integration
`include "ccs_regs.vh"
module ccs_ctrl #(
   parameter STEP_CYCLES = `CCS_STEP_CYCLES
) (
   input wire clock,
   input wire rst,
   input wire clock_en,
   input wire reg_wr,
   input wire [4:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   input wire sf_cmd,
   input wire [4:0] sf_code,
   input wire [15:0] clear_sample,
   output reg [15:0] clear_result,
   output reg irq,
   output wire osc_running,
   output wire integrating
);
   // ****************************************************************
   // States
   // ****************************************************************
   localparam ST_OFF = 2'd0;
   localparam ST_WARM = 2'd1;
   localparam ST_INTEG = 2'd2;
   localparam ST_WAIT = 2'd3;
   localparam [5:0] FILTER_TOP = 6'h3f; // Filter count saturation

   // Register file
   reg [7:0] function_control;
   reg [7:0] integration_time;
   reg [7:0] wait_time;
   reg [7:0] low_threshold_lower_byte;
   reg [7:0] low_threshold_upper_byte;
   reg [7:0] high_threshold_lower_byte;
   reg [7:0] high_threshold_upper_byte;
   reg [7:0] interrupt_filter;
   reg [7:0] wait_config;
   // Sequencer and filter state
   reg [1:0] state;
   reg [1:0] next_state;
   reg [8:0] steps;
   reg [3:0] sub_step;
   reg [5:0] out_count;
   reg [5:0] next_out_count;
   reg result_valid;
   reg next_irq;
   reg step_run;
   // Decoded fields and datapath
   wire step_pulse;
   wire oscillator_on;
   wire measure_on;
   wire wait_on;
   wire irq_allow;
   wire wait_x12;
   wire [15:0] low_thr;
   wire [15:0] high_thr;
   wire out_of_range;
   wire [5:0] need;
   wire wait_tick;
   wire integ_end;
   wire wait_end;
   wire irq_clear;
   wire [16:0] full_scale;
   wire [15:0] sat_sample;

   // Steps of a period for a two's complement setting
   function [8:0] period_steps;
      input [7:0] setting;
      begin
         period_steps = 9'h100 - {1'b0, setting};
      end
   endfunction

   // Required consecutive out-of-range count for a filter code
   function [5:0] filter_need;
      input [3:0] code;
      begin
         if (code < 4'h4) begin
            filter_need = {2'b00, code};
         end else begin
            filter_need = 6'd5 * ({2'b00, code} - 6'd3);
         end
      end
   endfunction

   // Saturated full scale; 19 bits so 256 steps cannot wrap to zero
   function [16:0] scale_limit;
      input [7:0] setting;
      reg [18:0] raw;
      begin
         raw = {10'h000, period_steps(setting)} * `CCS_COUNTS_PER_STEP;
         if (raw > {2'b00, `CCS_MAX_COUNT}) begin
            scale_limit = `CCS_MAX_COUNT;
         end else begin
            scale_limit = raw[16:0];
         end
      end
   endfunction

   assign oscillator_on = function_control[`CCS_BIT_OSC_ON];
   assign measure_on = function_control[`CCS_BIT_MEASURE_ON];
   assign wait_on = function_control[`CCS_BIT_WAIT_ON];
   assign irq_allow = function_control[`CCS_BIT_IRQ_ALLOW];
   assign wait_x12 = wait_config[`CCS_BIT_WAIT_X12];
   assign low_thr = {low_threshold_upper_byte, low_threshold_lower_byte};
   assign high_thr = {high_threshold_upper_byte, high_threshold_lower_byte};
   assign need = filter_need(interrupt_filter[3:0]);
   assign osc_running = oscillator_on;
   assign integrating = (state == ST_INTEG);
   assign irq_clear = sf_cmd && (sf_code == `CCS_SF_IRQ_CLEAR);

   // ****************************************************************
   // Step timer
   // ****************************************************************
   ccs_step_timer #(
      .STEP_CYCLES(STEP_CYCLES),
      .WIDTH(24)
   ) u_step (
      .clock(clock),
      .rst(rst),
      .clock_en(clock_en),
      .run(step_run),
      .step_done(step_pulse)
   );

   // Timer runs only with oscillator on and sequencing active
   always @* begin
      step_run = oscillator_on && (state != ST_OFF);
   end

   // Long wait divides step pulses by twelve
   assign wait_tick = step_pulse && (!wait_x12 ||
      (sub_step == `CCS_LONG_LAST));
   assign integ_end = (state == ST_INTEG) && step_pulse && (steps == 9'd1);
   assign wait_end = (state == ST_WAIT) && wait_tick && (steps == 9'd1);

   // Saturated full scale of the running integration
   assign full_scale = scale_limit(integration_time);
   assign sat_sample = ({1'b0, clear_sample} > full_scale) ? full_scale[15:0] :
      clear_sample;
   assign out_of_range = (sat_sample < low_thr) || (sat_sample > high_thr);

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (oscillator_on) begin
               next_state = ST_WARM;
            end
         end
         ST_WARM: begin
            if (step_pulse && measure_on) begin
               next_state = ST_INTEG;
            end
         end
         ST_INTEG: begin
            if (!measure_on) begin
               next_state = ST_WARM;
            end else if (integ_end) begin
               next_state = wait_on ? ST_WAIT : ST_INTEG;
            end
         end
         default: begin
            if (!measure_on) begin
               next_state = ST_WARM;
            end else if (wait_end || !wait_on) begin
               next_state = ST_INTEG;
            end
         end
      endcase
      if (!oscillator_on) begin
         next_state = ST_OFF;
      end
   end

   // State, step counts and sub-step divider
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= ST_OFF;
         steps <= 9'd0;
         sub_step <= 4'd0;
      end else if (clock_en) begin
         state <= next_state;
         if (next_state == ST_INTEG && state != ST_INTEG) begin
            steps <= period_steps(integration_time);
         end else if (next_state == ST_INTEG && integ_end) begin
            steps <= period_steps(integration_time);
         end else if (next_state == ST_WAIT && state != ST_WAIT) begin
            steps <= period_steps(wait_time);
            sub_step <= 4'd0;
         end else if (state == ST_INTEG && step_pulse) begin
            steps <= steps - 9'd1;
         end else if (state == ST_WAIT && step_pulse) begin
            if (wait_tick) begin
               steps <= steps - 9'd1;
               sub_step <= 4'd0;
            end else begin
               sub_step <= sub_step + 4'd1;
            end
         end
      end
   end

   // ****************************************************************
   // Result, filter and interrupt
   // ****************************************************************
   // Filter count and interrupt level for the coming edge
   always @* begin
      next_out_count = out_count;
      next_irq = irq;
      if (integ_end) begin
         if (!out_of_range) begin
            next_out_count = 6'd0;
         end else if (out_count != FILTER_TOP) begin
            next_out_count = out_count + 6'd1;
         end
      end
      // Raise wins over a clear; 7-bit sum so a full count still raises
      if (integ_end && irq_allow && ((need == 6'd0) ||
          (out_of_range && ({1'b0, out_count} + 7'd1 >= {1'b0, need})))) begin
         next_irq = 1'b1;
      end else if (irq_clear) begin
         next_irq = 1'b0;
      end
   end

   // Result register, valid flag, filter count and interrupt level
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         clear_result <= 16'h0000;
         result_valid <= 1'b0;
         out_count <= 6'd0;
         irq <= 1'b0;
      end else if (clock_en) begin
         out_count <= next_out_count;
         irq <= next_irq;
         if (integ_end) begin
            clear_result <= sat_sample;
            result_valid <= 1'b1;
         end else if (!oscillator_on) begin
            result_valid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         function_control <= `CCS_RST_FUNC_CTRL;
         integration_time <= `CCS_RST_INTEG_TIME;
         wait_time <= `CCS_RST_WAIT_TIME;
         low_threshold_lower_byte <= `CCS_RST_ZERO;
         low_threshold_upper_byte <= `CCS_RST_ZERO;
         high_threshold_lower_byte <= `CCS_RST_ZERO;
         high_threshold_upper_byte <= `CCS_RST_ZERO;
         interrupt_filter <= `CCS_RST_ZERO;
         wait_config <= `CCS_RST_ZERO;
      end else if (clock_en && reg_wr) begin
         if (reg_addr == `CCS_ADDR_FUNC_CTRL) begin
            function_control <= reg_wdata & `CCS_FUNC_CTRL_MASK;
         end else if (reg_addr == `CCS_ADDR_INTEG_TIME) begin
            integration_time <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_WAIT_TIME) begin
            wait_time <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_LOW_THR_LO) begin
            low_threshold_lower_byte <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_LOW_THR_HI) begin
            low_threshold_upper_byte <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_HIGH_THR_LO) begin
            high_threshold_lower_byte <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_HIGH_THR_HI) begin
            high_threshold_upper_byte <= reg_wdata;
         end else if (reg_addr == `CCS_ADDR_INT_FILTER) begin
            interrupt_filter <= reg_wdata & `CCS_FILTER_MASK;
         end else if (reg_addr == `CCS_ADDR_WAIT_CONFIG) begin
            wait_config <= reg_wdata & `CCS_WAIT_CONFIG_MASK;
         end
      end
   end

   // ****************************************************************
   // Register reads (registered)
   // ****************************************************************
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clock_en) begin
         if (reg_addr == `CCS_ADDR_FUNC_CTRL) begin
            reg_rdata <= function_control;
         end else if (reg_addr == `CCS_ADDR_INTEG_TIME) begin
            reg_rdata <= integration_time;
         end else if (reg_addr == `CCS_ADDR_WAIT_TIME) begin
            reg_rdata <= wait_time;
         end else if (reg_addr == `CCS_ADDR_LOW_THR_LO) begin
            reg_rdata <= low_threshold_lower_byte;
         end else if (reg_addr == `CCS_ADDR_LOW_THR_HI) begin
            reg_rdata <= low_threshold_upper_byte;
         end else if (reg_addr == `CCS_ADDR_HIGH_THR_LO) begin
            reg_rdata <= high_threshold_lower_byte;
         end else if (reg_addr == `CCS_ADDR_HIGH_THR_HI) begin
            reg_rdata <= high_threshold_upper_byte;
         end else if (reg_addr == `CCS_ADDR_INT_FILTER) begin
            reg_rdata <= interrupt_filter;
         end else if (reg_addr == `CCS_ADDR_WAIT_CONFIG) begin
            reg_rdata <= wait_config;
         end else if (reg_addr == `CCS_ADDR_STATUS) begin
            reg_rdata <= {3'b000, irq, 3'b000, result_valid};
         end else if (reg_addr == `CCS_ADDR_CLEAR_LO) begin
            reg_rdata <= clear_result[7:0];
         end else if (reg_addr == `CCS_ADDR_CLEAR_HI) begin
            reg_rdata <= clear_result[15:8];
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end
endmodule

// ---- ccs_ctrl_asserts.sv ----
// Port checker of the colour sensor control
module ccs_ctrl_asserts #(
   parameter STEP_CYCLES = 600000
) (
   input wire clock,
   input wire rst,
   input wire clock_en,
   input wire reg_wr,
   input wire [4:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire sf_cmd,
   input wire [4:0] sf_code,
   input wire [15:0] clear_sample,
   input wire [15:0] clear_result,
   input wire irq,
   input wire osc_running,
   input wire integrating
);
   // ****************************************************************
   // Shadow of control and integration settings
   // ****************************************************************
   logic [7:0] fc_q;
   logic [7:0] it_q;
   logic [18:0] full;
   logic [15:0] lim;
   // Follow host writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fc_q <= 8'h00;
         it_q <= 8'hff;
      end else if (clock_en && reg_wr && reg_addr == 5'h00) begin
         fc_q <= reg_wdata & 8'h1b;
      end else if (clock_en && reg_wr && reg_addr == 5'h01) begin
         it_q <= reg_wdata;
      end
   end
   // Full scale of the current setting
   assign full = (19'h00100 - {11'h000, it_q}) << 10;
   assign lim = (full > 19'h0ffff) ? 16'hffff : full[15:0];
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_osc_follows_write: assert property (clock_en && reg_wr && reg_addr == 5'h00 |=>
      osc_running == $past(reg_wdata[0])) else $error("oscillator bit not followed");
   a_idle_when_off: assert property (!osc_running [*2] |-> !integrating)
      else $error("integrating while oscillator off");
   a_idle_no_measure: assert property (!fc_q[1] [*3] |-> !integrating)
      else $error("integrating while measurement off");
   a_warmup_delay: assert property ($rose(integrating) |->
      $past(osc_running, STEP_CYCLES)) else $error("integration began too early");
   a_irq_allowed: assert property ($rose(irq) |-> $past(fc_q[4]))
      else $error("interrupt raised while not allowed");
   a_irq_at_end: assert property ($rose(irq) |-> $past(integrating))
      else $error("interrupt raised outside integration end");
   a_clear_drops_irq: assert property (sf_cmd && clock_en && sf_code == 5'h06
      && !integrating |=> !irq) else $error("interrupt not cleared");
   a_irq_level_held: assert property (irq && !(sf_cmd && sf_code == 5'h06) |=> irq)
      else $error("interrupt dropped without clear");
   a_result_saturates: assert property ($changed(clear_result) |-> clear_result ==
      (($past(clear_sample) > lim) ? lim : $past(clear_sample)))
      else $error("clear result not saturated sample");
   a_read_control: assert property (clock_en && !reg_wr && reg_addr == 5'h00 |=>
      reg_rdata == fc_q) else $error("control register read wrong");
   c_irq_raise: cover property ($rose(irq));
   c_irq_clear: cover property (sf_cmd && sf_code == 5'h06 && irq);
   c_integ_start: cover property ($rose(integrating));
endmodule
bind ccs_ctrl ccs_ctrl_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.clock(clock), .rst(rst),
   .clock_en(clock_en), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .sf_cmd(sf_cmd), .sf_code(sf_code), .clear_sample(clear_sample),
   .clear_result(clear_result), .irq(irq), .osc_running(osc_running),
   .integrating(integrating));

// ---- ccs_host.sv ----
// Host model driving the register and command strobes
module ccs_host (
   input wire clock,
   output logic reg_wr,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic sf_cmd,
   output logic [4:0] sf_code,
   input wire [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      sf_cmd = 1'b0;
      sf_code = 5'h00;
   end
   // One write cycle, unused control bits sent as zero
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = (a == 5'h00) ? (d & 8'h1b) : d;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask
   // Address then take registered data
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      @(negedge clock);
      d = reg_rdata;
   endtask
   // Interrupt clear command
   task automatic clr();
      @(negedge clock);
      sf_cmd = 1'b1;
      sf_code = 5'h06;
      @(negedge clock);
      sf_cmd = 1'b0;
      sf_code = 5'h1f;
   endtask
endmodule

// ---- ccs_ctrl_test.sv ----
// Self-checking testbench of the colour sensor control
module ccs_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STEP = 10;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clock_en = 1'b1;
   logic [15:0] clear_sample = 16'h1234;
   wire reg_wr;
   wire [4:0] reg_addr;
   wire [7:0] reg_wdata;
   wire sf_cmd;
   wire [4:0] sf_code;
   wire [7:0] reg_rdata;
   wire [15:0] clear_result;
   wire irq;
   wire osc_running;
   wire integrating;
   int errors = 0;
   int n_tests = 0;
   logic [7:0] d;
   int c;
   always #2 clock = ~clock;
   ccs_host host (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .sf_cmd(sf_cmd), .sf_code(sf_code), .reg_rdata(reg_rdata));
   ccs_ctrl #(.STEP_CYCLES(STEP)) dut (.clock(clock), .rst(rst), .clock_en(clock_en),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sf_cmd(sf_cmd), .sf_code(sf_code), .clear_sample(clear_sample),
      .clear_result(clear_result), .irq(irq), .osc_running(osc_running),
      .integrating(integrating));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rcmp(input logic [4:0] a, input logic [7:0] exp);
      host.rd(a, d);
      cmp({8'h00, d}, {8'h00, exp});
   endtask
   // Cycles spent at one level of integrating, bounded
   task automatic dur(input logic lv);
      c = 0;
      while (integrating === lv && c < 3000) begin
         @(negedge clock);
         c++;
      end
      if (c >= 3000) begin
         errors++;
         give_verdict();
      end
   endtask
   task automatic ends(input int n);
      repeat (n) begin
         dur(1'b0);
         dur(1'b1);
      end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      logic [4:0] ra [10] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d,
         5'h02};
      for (int i = 0; i < 10; i++) begin
         rcmp(ra[i], (i == 1 || i == 2) ? 8'hff : 8'h00);
      end
   endtask
   task automatic t_timing();
      host.wr(5'h01, 8'hfe);
      host.wr(5'h03, 8'hfe);
      host.wr(5'h00, 8'h0b);
      dur(1'b0);
      cmp(16'(c >= STEP), 16'h1);
      dur(1'b1);
      cmp(16'(c >= 2 * STEP - 2 && c <= 2 * STEP + 2), 16'h1);
      dur(1'b0);
      cmp(16'(c >= 2 * STEP - 2 && c <= 2 * STEP + 2), 16'h1);
      host.wr(5'h0d, 8'h02);
      dur(1'b1);
      dur(1'b0);
      cmp(16'(c >= 24 * STEP - 2 && c <= 24 * STEP + 2), 16'h1);
      cmp(clear_result, 16'h0800);
      rcmp(5'h14, 8'h00);
      rcmp(5'h15, 8'h08);
      rcmp(5'h13, 8'h01);
      host.wr(5'h0d, 8'h00);
      host.wr(5'h00, 8'h01);
      repeat (3 * STEP) @(negedge clock);
      cmp(integrating, 1'b0);
      host.wr(5'h00, 8'h00);
      cmp(osc_running, 1'b0);
   endtask
   task automatic t_irq();
      host.wr(5'h01, 8'hff);
      host.wr(5'h03, 8'hff);
      host.wr(5'h04, 8'h00);
      host.wr(5'h05, 8'h01);
      host.wr(5'h06, 8'h00);
      host.wr(5'h07, 8'h03);
      rcmp(5'h05, 8'h01);
      rcmp(5'h07, 8'h03);
      clear_sample = 16'h0050;
      host.wr(5'h00, 8'h0b);
      ends(2);
      cmp(irq, 1'b0);
      host.wr(5'h00, 8'h1b);
      ends(1);
      cmp(irq, 1'b1);
      rcmp(5'h13, 8'h11);
      host.wr(5'h0c, 8'h02);
      host.clr();
      cmp(irq, 1'b0);
      clear_sample = 16'h0200;
      ends(2);
      cmp(irq, 1'b0);
      clear_sample = 16'h0050;
      ends(1);
      cmp(irq, 1'b0);
      ends(1);
      cmp(irq, 1'b1);
      host.wr(5'h0c, 8'h01);
      host.clr();
      clear_sample = 16'h0350;
      ends(1);
      cmp(irq, 1'b1);
      clear_sample = 16'h0200;
      ends(1);
      cmp(irq, 1'b1);
   endtask
   // Longest integration: 256 steps, result saturates at full 16 bits
   task automatic t_full_scale();
      host.wr(5'h01, 8'h00);
      clear_sample = 16'hffff;
      dur(1'b0);
      dur(1'b1);
      cmp(16'(c >= 256 * STEP - 2 && c <= 256 * STEP + 2), 16'h1);
      cmp(clear_result, 16'hffff);
      rcmp(5'h14, 8'hff);
   endtask
   // Main sequence
   initial begin
      repeat (5) @(negedge clock);
      rst = 1'b0;
      t_reset();
      t_timing();
      t_irq();
      t_full_scale();
      give_verdict();
   end
endmodule
